/* pkg/serial_rx_pkg.sv */
// constants for the serial receive port with flow control
// assumes a single clock and a plain register port
package serial_rx_pkg;
    // register offsets
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_STATUS  = 4'h4;
    localparam logic [3:0]  REG_DATA    = 4'h8;
    localparam logic [3:0]  REG_FREE    = 4'hC;
    // control fields
    localparam int          CTRL_RATE_LSB = 0;
    localparam int          CTRL_DATA8    = 3;
    localparam int          CTRL_PAR_LSB  = 4;
    localparam int          CTRL_ETX      = 6;
    localparam logic [6:0]  CTRL_RESET    = 7'h0D;
    // status fields
    localparam int          ST_PERR     = 0;
    localparam int          ST_FERR     = 1;
    localparam int          ST_OVR      = 2;
    localparam int          ST_READY    = 3;
    localparam int          ST_EMPTY    = 4;
    localparam int          ST_CNT_LSB  = 8;
    // buffer space thresholds in bytes
    localparam int          FREE_W      = 16;
    localparam logic [15:0] LOW_MARK    = 16'h0100;
    localparam logic [15:0] HIGH_MARK   = 16'h0200;
    localparam logic [15:0] FREE_RESET  = 16'h2000;
    // character codes
    localparam logic [7:0]  CH_ETX      = 8'h03;
    localparam logic [7:0]  CH_ACK      = 8'h06;
    localparam logic [7:0]  CH_NAK      = 8'h15;
    localparam logic [7:0]  CH_XON      = 8'h11;
    localparam logic [7:0]  CH_XOFF     = 8'h13;
    // bit rates: base rate doubled per select step
    localparam int          RATE_BASE   = 300;
    localparam logic [2:0]  RATE_MAX    = 3'h6;
    localparam int          CNT_W       = 20;
    localparam int          CLK_HZ_DEF  = 125_000_000;
    localparam int          FIFO_DEPTH  = 32;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ODD  = 2'b01,
        PAR_EVEN = 2'b10
    } parity_t;

    typedef enum logic [2:0] {
        SER_IDLE  = 3'b000,
        SER_START = 3'b001,
        SER_DATA  = 3'b010,
        SER_PAR   = 3'b011,
        SER_STOP  = 3'b100
    } ser_state_t;
endpackage : serial_rx_pkg

/* rtl/serial_rx_flow.sv */
// serial receive port: frame receiver, buffer fifo, flow control replies
// assumes rxd synchronous to clk; firmware reports its buffer space in REG_FREE
//
// Functional notes
// [RL1] below 256 free: drop ready, send pause
// [RL2] above 512 free: raise ready, send resume
// [RL3] end-of-text mode: reply NAK below 256
// [RL4] end-of-text mode: reply ACK at 256+
// [RL5] one start bit, 7 or 8 data
// [RL6] parity none, odd or even
// [RL7] send one stop, accept longer stops
// [RL8] rates 300 to 19200 selectable
// [RL9] request-to-send always asserted
// [RL10] ready line follows acceptance state
// [RL11] 8-bit async characters, level plus in-band flow
// [RL12] hold flow state between thresholds
// [RL13] clear-to-send input ignored

////////////////////////////////////////////////////////////////////////////////
// buffer fifo
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // fill side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // drain side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    // honest full and empty
    assign in_ready  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule : byte_fifo

////////////////////////////////////////////////////////////////////////////////
// top level
module serial_rx_flow
    import serial_rx_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_DEF,
    parameter int DEPTH  = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic [31:0]            rdata,
    // serial line
    input  wire logic              rxd,
    output logic                   txd,
    output logic                   rts_out,
    output logic                   dtr_out,
    input  wire logic              cts_in
);
    localparam int CW = $clog2(DEPTH+1);

    // bit period in clocks for a rate select
    function automatic logic [CNT_W-1:0] bit_cycles(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > RATE_MAX) ? RATE_MAX : sel;
        return CNT_W'(CLK_HZ / (RATE_BASE << s));
    endfunction : bit_cycles

    logic [6:0]        ctrl;
    logic [FREE_W-1:0] free_reg;
    logic [FREE_W-1:0] free_eff;
    logic [CNT_W-1:0]  period;
    logic              data8;
    parity_t           par_mode;
    logic              etx_mode;
    logic              perr;
    logic              ferr;
    logic              ovr;
    logic              flow_ready;
    logic              want_xoff;
    logic              want_xon;
    logic              want_reply;
    logic [7:0]        reply_code;
    logic [CW-1:0]     fifo_cnt;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [7:0]        fifo_out_data;
    logic              pop;

    assign period   = bit_cycles(ctrl[CTRL_RATE_LSB +: 3]);
    assign data8    = ctrl[CTRL_DATA8];
    assign par_mode = parity_t'(ctrl[CTRL_PAR_LSB +: 2]);
    assign etx_mode = ctrl[CTRL_ETX];
    assign free_eff = (free_reg > FREE_W'(fifo_cnt)) ? free_reg - FREE_W'(fifo_cnt) : '0;

    ////////////////////////////////////////////////////////////////////////////
    // receiver
    ser_state_t       rx_state;
    logic [CNT_W-1:0] rx_cnt;
    logic [2:0]       rx_idx;
    logic [7:0]       rx_shift;
    logic             rx_par;
    logic             rxd_q;
    logic             rx_done;
    logic             rx_bad;

    // [RL5] start bit, data field
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state <= SER_IDLE;
            rx_cnt   <= '0;
            rx_idx   <= '0;
            rx_shift <= '0;
            rx_par   <= 1'b0;
            rxd_q    <= 1'b1;
            rx_done  <= 1'b0;
            rx_bad   <= 1'b0;
        end else begin
            rxd_q   <= rxd;
            rx_done <= 1'b0;
            case (rx_state)
                SER_IDLE: begin
                    if (rxd_q && !rxd) begin
                        rx_state <= SER_START;
                        rx_cnt   <= period >> 1;
                        rx_bad   <= 1'b0;
                    end
                end
                SER_START: begin
                    if (rx_cnt == '0) begin
                        rx_state <= rxd ? SER_IDLE : SER_DATA;
                        rx_cnt   <= period - 1'b1;
                        rx_idx   <= '0;
                        rx_shift <= '0;
                        rx_par   <= 1'b0;
                    end else begin
                        rx_cnt <= rx_cnt - 1'b1;
                    end
                end
                SER_DATA: begin
                    if (rx_cnt == '0) begin
                        rx_shift[rx_idx] <= rxd;
                        rx_par           <= rx_par ^ rxd;
                        rx_idx           <= rx_idx + 1'b1;
                        rx_cnt           <= period - 1'b1;
                        if (rx_idx == (data8 ? 3'h7 : 3'h6)) begin
                            rx_state <= (par_mode == PAR_NONE) ? SER_STOP : SER_PAR;
                        end
                    end else begin
                        rx_cnt <= rx_cnt - 1'b1;
                    end
                end
                // [RL6] parity check
                SER_PAR: begin
                    if (rx_cnt == '0) begin
                        rx_bad   <= ((rx_par ^ rxd) != (par_mode == PAR_ODD));
                        rx_state <= SER_STOP;
                        rx_cnt   <= period - 1'b1;
                    end else begin
                        rx_cnt <= rx_cnt - 1'b1;
                    end
                end
                // [RL7] one stop checked, extra idle accepted
                default: begin
                    if (rx_cnt == '0) begin
                        rx_state <= SER_IDLE;
                        rx_done  <= rxd;
                    end else begin
                        rx_cnt <= rx_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    logic stop_bad;
    assign stop_bad = (rx_state == SER_STOP) && (rx_cnt == '0) && !rxd;

    // [RL11] 8-bit characters into the buffer
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (rx_done && !rx_bad),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_shift),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .count     (fifo_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers; sticky errors, set wins over write-one clear
    logic st_wr;
    assign st_wr = wr_stb && (addr == REG_STATUS);
    assign pop   = rd_stb && (addr == REG_DATA);

    // control and free space
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl     <= CTRL_RESET;
            free_reg <= FREE_RESET;
        end else if (wr_stb) begin
            if (addr == REG_CTRL) begin
                ctrl <= wdata[6:0];
            end else if (addr == REG_FREE) begin
                free_reg <= wdata[FREE_W-1:0];
            end
        end
    end

    // error flags
    always_ff @(posedge clk) begin
        if (srst) begin
            perr <= 1'b0;
            ferr <= 1'b0;
            ovr  <= 1'b0;
        end else begin
            perr <= (rx_done && rx_bad) || (perr && !(st_wr && wdata[ST_PERR]));
            ferr <= stop_bad || (ferr && !(st_wr && wdata[ST_FERR]));
            ovr  <= (rx_done && !rx_bad && !fifo_in_ready) || (ovr && !(st_wr && wdata[ST_OVR]));
        end
    end

    // read data, valid only the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
        end else if (!rd_stb) begin
            rdata <= '0;
        end else if (addr == REG_CTRL) begin
            rdata <= {25'h0, ctrl};
        end else if (addr == REG_STATUS) begin
            rdata <= '0;
            rdata[ST_PERR]             <= perr;
            rdata[ST_FERR]             <= ferr;
            rdata[ST_OVR]              <= ovr;
            rdata[ST_READY]            <= dtr_out;
            rdata[ST_EMPTY]            <= !fifo_out_valid;
            rdata[ST_CNT_LSB +: CW]    <= fifo_cnt;
        end else if (addr == REG_DATA) begin
            rdata <= {24'h0, fifo_out_valid ? fifo_out_data : 8'h00};
        end else if (addr == REG_FREE) begin
            rdata <= {16'h0, free_eff};
        end else begin
            rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flow control
    ser_state_t tx_state;
    logic       tx_load;
    logic       send_xoff;
    logic       send_xon;
    assign tx_load   = (tx_state == SER_IDLE) && (want_xoff || want_xon || want_reply);
    assign send_xoff = !etx_mode && flow_ready && (free_eff < LOW_MARK);
    assign send_xon  = !etx_mode && !flow_ready && (free_eff > HIGH_MARK);

    // [RL12] state held between the marks
    always_ff @(posedge clk) begin
        if (srst) begin
            flow_ready <= 1'b1;
        end else if (etx_mode) begin
            flow_ready <= 1'b1;
        // [RL1] busy below low mark
        end else if (send_xoff) begin
            flow_ready <= 1'b0;
        // [RL2] ready above high mark
        end else if (send_xon) begin
            flow_ready <= 1'b1;
        end
    end

    // pending pause and resume characters; a new request beats the load
    always_ff @(posedge clk) begin
        if (srst) begin
            want_xoff <= 1'b0;
            want_xon  <= 1'b0;
        end else begin
            want_xoff <= send_xoff || (want_xoff && !tx_load && !send_xon);
            want_xon  <= send_xon || (want_xon && !(tx_load && !want_xoff) && !send_xoff);
        end
    end

    // [RL3] [RL4] reply to end-of-text
    always_ff @(posedge clk) begin
        if (srst) begin
            want_reply <= 1'b0;
            reply_code <= CH_ACK;
        end else if (etx_mode && rx_done && !rx_bad && rx_shift == CH_ETX) begin
            want_reply <= 1'b1;
            reply_code <= (free_eff < LOW_MARK) ? CH_NAK : CH_ACK;
        end else if (tx_load && !want_xoff && !want_xon) begin
            want_reply <= 1'b0;
        end
    end

    // [RL9] request-to-send fixed; [RL10] ready line
    assign rts_out = 1'b1;
    assign dtr_out = etx_mode ? (free_eff >= LOW_MARK) : flow_ready;
    // [RL13] clear-to-send not used
    logic cts_unused;
    assign cts_unused = cts_in;

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    logic [CNT_W-1:0] tx_cnt;
    logic [2:0]       tx_idx;
    logic [7:0]       tx_shift;
    logic             tx_par;

    // [RL8] bit period from rate select
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state <= SER_IDLE;
            tx_cnt   <= '0;
            tx_idx   <= '0;
            tx_shift <= '0;
            tx_par   <= 1'b0;
            txd      <= 1'b1;
        end else begin
            case (tx_state)
                SER_IDLE: begin
                    txd <= 1'b1;
                    if (tx_load) begin
                        tx_state <= SER_START;
                        tx_shift <= want_xoff ? CH_XOFF : (want_xon ? CH_XON : reply_code);
                        tx_cnt   <= period - 1'b1;
                        tx_idx   <= '0;
                        tx_par   <= (par_mode == PAR_ODD);
                        txd      <= 1'b0;
                    end
                end
                SER_START, SER_DATA: begin
                    if (tx_cnt == '0) begin
                        tx_cnt <= period - 1'b1;
                        if (tx_state == SER_DATA && tx_idx == (data8 ? 3'h7 : 3'h6)) begin
                            tx_state <= (par_mode == PAR_NONE) ? SER_STOP : SER_PAR;
                            txd      <= (par_mode == PAR_NONE) ? 1'b1 : tx_par;
                        end else begin
                            tx_state <= SER_DATA;
                            txd      <= tx_shift[0];
                            tx_par   <= tx_par ^ tx_shift[0];
                            tx_shift <= tx_shift >> 1;
                            tx_idx   <= (tx_state == SER_DATA) ? tx_idx + 1'b1 : '0;
                        end
                    end else begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end
                end
                SER_PAR: begin
                    if (tx_cnt == '0) begin
                        tx_state <= SER_STOP;
                        tx_cnt   <= period - 1'b1;
                        txd      <= 1'b1;
                    end else begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end
                end
                // [RL7] exactly one stop bit
                default: begin
                    txd <= 1'b1;
                    if (tx_cnt == '0) begin
                        tx_state <= SER_IDLE;
                    end else begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_low_seen;
        !etx_mode && flow_ready && free_eff < LOW_MARK;
    endsequence
    sequence s_etx_rx;
        etx_mode && rx_done && !rx_bad && rx_shift == CH_ETX;
    endsequence

    property p_xoff;
        s_low_seen |=> !flow_ready && want_xoff && !dtr_out;
    endproperty
    a_xoff: assert property (p_xoff) else $error("no pause on low space"); // RL1
    property p_xon;
        !etx_mode && !flow_ready && free_eff > HIGH_MARK |=> flow_ready && want_xon;
    endproperty
    a_xon: assert property (p_xon) else $error("no resume on high space"); // RL2
    property p_nak;
        s_etx_rx and (free_eff < LOW_MARK) |=> want_reply && reply_code == CH_NAK;
    endproperty
    a_nak: assert property (p_nak) else $error("missing NAK"); // RL3
    property p_ack;
        s_etx_rx and (free_eff >= LOW_MARK) |=> want_reply && reply_code == CH_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("missing ACK"); // RL4
    property p_start;
        $fell(txd) && $past(tx_state) == SER_IDLE |-> tx_state == SER_START ##1 !txd;
    endproperty
    a_start: assert property (p_start) else $error("bad start bit"); // RL5
    property p_stop;
        tx_state == SER_STOP |-> txd;
    endproperty
    a_stop: assert property (p_stop) else $error("stop bit not high"); // RL7
    property p_rts;
        rts_out;
    endproperty
    a_rts: assert property (p_rts) else $error("rts dropped"); // RL9
    property p_hold;
        !etx_mode && $stable(etx_mode) && free_eff >= LOW_MARK && free_eff <= HIGH_MARK
            |=> flow_ready == $past(flow_ready);
    endproperty
    a_hold: assert property (p_hold) else $error("flow state moved"); // RL12
    property p_dtr;
        (!etx_mode && free_eff < LOW_MARK) ##1 !etx_mode |-> !dtr_out;
    endproperty
    a_dtr: assert property (p_dtr) else $error("ready line wrong"); // RL10
endmodule : serial_rx_flow

/* sim/host_serial_model.sv */
// host serial port model: sends frames on rxd, decodes reply characters on txd
// assumes the bench sets bit_cycles to match the rate selected in the block
module host_serial_model (
    // clock
    input  wire logic clk,
    // serial line
    output logic      rxd,
    input  wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;
    int         bit_cycles = 16;
    int         char_count = 0;
    logic [7:0] last_char  = 8'h00;

    // line idles at mark
    initial rxd = 1'b1;

    // one bit held for a whole bit period
    task automatic put_bit(input logic b);
        rxd <= b;
        repeat (bit_cycles) @(posedge clk);
    endtask : put_bit

    // stop count, stop 0 forces a framing fault
    task automatic send_char(input logic [7:0] ch, input int nbits, input logic [1:0] par,
                             input int stops, input logic bad_par);
        logic p;
        p = bad_par;
        @(posedge clk);
        put_bit(1'b0);
        for (int i = 0; i < nbits; i++) begin
            put_bit(ch[i]);
            p = p ^ ch[i];
        end
        if (par != 2'b00)
            put_bit(par == 2'b01 ? ~p : p);
        if (stops == 0)
            put_bit(1'b0);
        for (int i = 0; i < stops; i++)
            put_bit(1'b1);
        rxd <= 1'b1;
    endtask : send_char

    // reply decode, 8 data lsb first, one stop
    initial begin
        forever begin
            @(posedge clk);
            if (txd === 1'b0) begin
                repeat (bit_cycles / 2) @(posedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (bit_cycles) @(posedge clk);
                    last_char[i] = txd;
                end
                repeat (bit_cycles) @(posedge clk);
                char_count++;
            end
        end
    end
endmodule : host_serial_model

/* sim/serial_receive_flow_control_tb_top.sv */
// bench for the serial receive port: register tasks, host model, scenario tasks
// assumes a lowered CLK_HZ so that 9600 bit/s is 16 clocks per bit
module serial_receive_flow_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_rx_pkg::*;
    localparam int CLK_HZ = 153600;
    logic        clk, srst, wr_stb, rd_stb, rxd, txd, rts_out, dtr_out, cts_in;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    int          mismatches  = 0;
    int          check_count = 0;
    int          cycles      = 0;

    serial_rx_flow #(.CLK_HZ(CLK_HZ), .DEPTH(FIFO_DEPTH)) i_dut (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .rxd(rxd), .txd(txd), .rts_out(rts_out), .dtr_out(dtr_out), .cts_in(cts_in));
    host_serial_model i_host (.clk(clk), .rxd(rxd), .txd(txd));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, timeout
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////////////////////////
    // register port and line helpers
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask : rd_chk

    task automatic dtr_chk(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, rts_out, dtr_out}, {30'h0, 1'b1, exp}, "dtr");
    endtask : dtr_chk

    task automatic expect_char(input logic [7:0] exp, input logic none);
        int c0;
        c0 = i_host.char_count;
        for (int i = 0; i < 16 * i_host.bit_cycles && i_host.char_count == c0; i++)
            @(posedge clk);
        if (none)
            chk(32'(i_host.char_count - c0), 32'h0, "no reply");
        else begin
            chk(32'(i_host.char_count - c0), 32'h1, "reply count");
            chk({24'h0, i_host.last_char}, {24'h0, exp}, "reply");
        end
    endtask : expect_char

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk({29'h0, txd, rts_out, dtr_out}, 32'h7, "idle pins");
        rd_chk(REG_CTRL, 32'h0D, "ctrl");
        rd_chk(REG_FREE, 32'h2000, "free");
        rd_chk(REG_STATUS, 32'h18, "status");
        rd_chk(4'h1, 32'h0, "unmapped");
        rd_chk(REG_DATA, 32'h0, "empty pop");
    endtask : t_reset

    task automatic t_rates();
        for (int n = 0; n < 7; n++) begin
            wr(REG_CTRL, 32'h8 | 32'(n));
            i_host.bit_cycles = CLK_HZ / (RATE_BASE << n);
            cts_in <= 1'(n);
            i_host.send_char(8'hA5 ^ 8'(n), 8, 2'b00, 1, 1'b0);
            rd_chk(REG_DATA, 32'hA5 ^ 32'(n), "rate byte");
        end
    endtask : t_rates

    task automatic t_formats();
        logic [6:0] f_ctrl [4] = '{7'h26, 7'h1E, 7'h0E, 7'h16};
        logic [7:0] f_ch   [4] = '{8'hD5, 8'h81, 8'h7E, 8'h3C};
        logic [1:0] f_par  [4] = '{2'b10, 2'b01, 2'b00, 2'b01};
        int         f_stop [4] = '{2, 1, 3, 1};
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL, {25'h0, f_ctrl[k]});
            i_host.send_char(f_ch[k], f_ctrl[k][3] ? 8 : 7, f_par[k], f_stop[k], 1'b0);
            rd_chk(REG_DATA, {24'h0, f_ch[k] & (f_ctrl[k][3] ? 8'hFF : 8'h7F)}, "format");
        end
        wr(REG_CTRL, 32'h2E);
        i_host.send_char(8'h5A, 8, 2'b10, 1, 1'b1);
        rd_chk(REG_STATUS, 32'h19, "parity fault");
        i_host.send_char(8'h5A, 8, 2'b10, 0, 1'b0);
        rd_chk(REG_STATUS, 32'h1B, "stop fault");
        wr(REG_STATUS, 32'h3);
        rd_chk(REG_STATUS, 32'h18, "flags cleared");
    endtask : t_formats

    task automatic t_fill();
        wr(REG_CTRL, 32'h0E);
        for (int i = 0; i < 33; i++)
            i_host.send_char(8'(i), 8, 2'b00, 1, 1'b0);
        rd_chk(REG_STATUS, 32'h200C, "full");
        rd_chk(REG_FREE, 32'h1FE0, "eff free");
        for (int i = 0; i < 32; i++)
            rd_chk(REG_DATA, 32'(i), "drain");
        rd_chk(REG_STATUS, 32'h1C, "overrun");
        wr(REG_STATUS, 32'h4);
        rd_chk(REG_STATUS, 32'h18, "emptied");
    endtask : t_fill

    task automatic t_flow();
        wr(REG_CTRL, 32'h0D);
        i_host.bit_cycles = 16;
        wr(REG_FREE, 32'h0200);
        dtr_chk(1'b1);
        wr(REG_FREE, 32'h00FF);
        dtr_chk(1'b0);
        expect_char(CH_XOFF, 1'b0);
        wr(REG_FREE, 32'h0200);
        dtr_chk(1'b0);
        expect_char(8'h00, 1'b1);
        wr(REG_FREE, 32'h0201);
        dtr_chk(1'b1);
        expect_char(CH_XON, 1'b0);
    endtask : t_flow

    task automatic t_etx();
        wr(REG_CTRL, 32'h4D);
        wr(REG_FREE, 32'h0101);
        i_host.send_char(CH_ETX, 8, 2'b00, 1, 1'b0);
        expect_char(CH_ACK, 1'b0);
        rd_chk(REG_DATA, {24'h0, CH_ETX}, "etx byte");
        wr(REG_FREE, 32'h00FF);
        dtr_chk(1'b0);
        i_host.send_char(CH_ETX, 8, 2'b00, 1, 1'b0);
        expect_char(CH_NAK, 1'b0);
    endtask : t_etx

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        srst   = 1'b1;
        addr   = 4'h0;
        wdata  = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cts_in = 1'b0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_rates();
        t_formats();
        t_fill();
        t_flow();
        t_etx();
        give_verdict();
    end
endmodule : serial_receive_flow_control_tb_top
